// >>> uart_event_routing_regs.sv
`timescale 1ns/1ns
// ==========================================================
// Overview of operation
// - rx-started event published to chosen channel
// - tx-started event published to chosen channel
// - tx-stopped event published to chosen channel
// - publish enable gates forwarding; reset zero
// - end-of-rx shortcut fires rx start task
// - end-of-rx shortcut fires rx stop task
// - shortcut register read-write, resets disabled
// - enable bits for clear-to-send events
// - lost clear-to-send interrupts only when enabled
// - enable bits for rx byte, rx end
// - enable bits for tx byte, tx end
// - enable bits for error, rx timeout
// - enables for start/stop events; reset zero
// - set alias writes ones, ignores zeros
module uart_event_routing_regs #(
  parameter int NUM_CHANNELS = 16
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // event pulses from the uart core
  input  wire logic                    clear_to_send_event,
  input  wire logic                    clear_to_send_lost_event,
  input  wire logic                    rx_byte_ready_event,
  input  wire logic                    receive_buffer_end_event,
  input  wire logic                    tx_byte_sent_event,
  input  wire logic                    transmit_buffer_end_event,
  input  wire logic                    error_event,
  input  wire logic                    receive_timeout_event,
  input  wire logic                    receive_started_event,
  input  wire logic                    transmit_started_event,
  input  wire logic                    transmit_stopped_event,
  // tasks back to the uart core
  output logic                         receive_start_task,
  output logic                         receive_stop_task,
  // interconnect channels and interrupt
  output logic      [NUM_CHANNELS-1:0] channel_pulse,
  output logic                         irq
);
  import uart_evt_pkg::*;

  // ==========================================================
  // parameter check
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << CHAN_IDX_W)) begin : g_bad_channels
    $error("NUM_CHANNELS must lie between 1 and 16");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic                    wr_pend;
    logic [ADDR_W-1:0]       wr_addr;
    logic [CHAN_IDX_W:0]     pub_rxs;   // {enable, channel_index}
    logic [CHAN_IDX_W:0]     pub_txs;
    logic [CHAN_IDX_W:0]     pub_txp;
    logic                    sc_start;
    logic                    sc_stop;
    logic [31:0]             int_mask;
    logic [31:0]             status;
    logic [31:0]             rdata;
    logic [NUM_CHANNELS-1:0] chan;
    logic                    start_task;
    logic                    stop_task;
    logic                    irq;
    logic                    ready;
    logic                    resp;
  } state_t;

  localparam state_t STATE_RESET = '{
    wr_pend:    1'b0,
    wr_addr:    '0,
    pub_rxs:    PUB_RESET[CHAN_IDX_W:0],
    pub_txs:    PUB_RESET[CHAN_IDX_W:0],
    pub_txp:    PUB_RESET[CHAN_IDX_W:0],
    sc_start:   SHORTCUT_RESET[SC_START_BIT],
    sc_stop:    SHORTCUT_RESET[SC_STOP_BIT],
    int_mask:   INT_MASK_RESET,
    status:     STATUS_RESET,
    rdata:      RDATA_NONE,
    chan:       '0,
    start_task: 1'b0,
    stop_task:  1'b0,
    irq:        1'b0,
    ready:      1'b1,
    resp:       HRESP_OKAY
  };

  state_t                  s_reg;
  state_t                  s_next;
  logic   [31:0]           ev_vec;
  logic   [NUM_CHANNELS-1:0] hit_rxs;
  logic   [NUM_CHANNELS-1:0] hit_txs;
  logic   [NUM_CHANNELS-1:0] hit_txp;
  logic                    accept;

  // ==========================================================
  // event vector in interrupt layout
  always_comb begin
    ev_vec             = '0;
    ev_vec[IB_CTS]     = clear_to_send_event;
    ev_vec[IB_CTS_LOST]   = clear_to_send_lost_event;
    ev_vec[IB_RXRDY]      = rx_byte_ready_event;
    ev_vec[IB_RX_END]     = receive_buffer_end_event;
    ev_vec[IB_TXSENT]     = tx_byte_sent_event;
    ev_vec[IB_TX_END]     = transmit_buffer_end_event;
    ev_vec[IB_ERROR]      = error_event;
    ev_vec[IB_RX_TIMEOUT] = receive_timeout_event;
    ev_vec[IB_RXSTART] = receive_started_event;
    ev_vec[IB_TXSTART] = transmit_started_event;
    ev_vec[IB_TXSTOP]  = transmit_stopped_event;
  end

  // ==========================================================
  // publishers, one per routed event
  // rx-started publisher
  event_publisher #(.NUM_CHANNELS(NUM_CHANNELS)) u_pub_rxs (
    .evt      (receive_started_event),
    .enable   (s_reg.pub_rxs[CHAN_IDX_W]),
    .chan_idx (s_reg.pub_rxs[CHAN_IDX_W-1:0]),
    .chan_hit (hit_rxs)
  );

  event_publisher #(.NUM_CHANNELS(NUM_CHANNELS)) u_pub_txs (
    .evt      (transmit_started_event),
    .enable   (s_reg.pub_txs[CHAN_IDX_W]),
    .chan_idx (s_reg.pub_txs[CHAN_IDX_W-1:0]),
    .chan_hit (hit_txs)
  );

  event_publisher #(.NUM_CHANNELS(NUM_CHANNELS)) u_pub_txp (
    .evt      (transmit_stopped_event),
    .enable   (s_reg.pub_txp[CHAN_IDX_W]),
    .chan_idx (s_reg.pub_txp[CHAN_IDX_W-1:0]),
    .chan_hit (hit_txp)
  );

  // address phase taken only when the bus is ready
  assign accept = hsel && htrans[HTRANS_ACT_BIT] && hready;

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] clr;
    logic [31:0] wd;
    clr    = '0;
    wd     = hwdata & INT_VALID;
    s_next = s_reg;

    // channel drive, several events may share a channel
    s_next.chan = hit_rxs | hit_txs | hit_txp;

    s_next.start_task = s_reg.sc_start && receive_buffer_end_event;
    s_next.stop_task  = s_reg.sc_stop && receive_buffer_end_event;

    // data phase of a write
    if (s_reg.wr_pend) begin
      unique case (s_reg.wr_addr)
        OFS_PUB_RXSTART: s_next.pub_rxs = {hwdata[PUB_EN_BIT], hwdata[CHAN_IDX_W-1:0]};
        OFS_PUB_TXSTART: s_next.pub_txs = {hwdata[PUB_EN_BIT], hwdata[CHAN_IDX_W-1:0]};
        OFS_PUB_TXSTOP:  s_next.pub_txp = {hwdata[PUB_EN_BIT], hwdata[CHAN_IDX_W-1:0]};
        OFS_SHORTCUTS: begin
          s_next.sc_start = hwdata[SC_START_BIT];
          s_next.sc_stop  = hwdata[SC_STOP_BIT];
        end
        OFS_INT_MASK:   s_next.int_mask = wd;
        OFS_INT_SET:    s_next.int_mask = s_reg.int_mask | wd;
        OFS_INT_STATUS: clr = wd;
        default: ;
      endcase
    end

    // sticky status, a new event beats the clear
    s_next.status = (s_reg.status & ~clr) | ev_vec;

    s_next.irq = |(s_next.status & s_next.int_mask);

    // address phase: capture write, prepare read data
    s_next.wr_pend = accept && hwrite;
    s_next.wr_addr = haddr[ADDR_W-1:0];
    s_next.ready   = 1'b1;
    if (accept && !hwrite) begin
      unique case (haddr[ADDR_W-1:0])
        OFS_PUB_RXSTART: s_next.rdata = {s_next.pub_rxs[CHAN_IDX_W], 26'h0,
                                         1'b0, s_next.pub_rxs[CHAN_IDX_W-1:0]};
        OFS_PUB_TXSTART: s_next.rdata = {s_next.pub_txs[CHAN_IDX_W], 26'h0,
                                         1'b0, s_next.pub_txs[CHAN_IDX_W-1:0]};
        OFS_PUB_TXSTOP:  s_next.rdata = {s_next.pub_txp[CHAN_IDX_W], 26'h0,
                                         1'b0, s_next.pub_txp[CHAN_IDX_W-1:0]};
        OFS_SHORTCUTS: begin
          s_next.rdata               = '0;
          s_next.rdata[SC_START_BIT] = s_next.sc_start;
          s_next.rdata[SC_STOP_BIT]  = s_next.sc_stop;
        end
        OFS_INT_MASK:   s_next.rdata = s_next.int_mask;
        OFS_INT_SET:    s_next.rdata = s_next.int_mask;
        OFS_INT_STATUS: s_next.rdata = s_next.status;
        default:        s_next.rdata = RDATA_NONE;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign hrdata             = s_reg.rdata;
  assign hreadyout          = s_reg.ready;
  assign hresp              = s_reg.resp;
  assign channel_pulse      = s_reg.chan;
  assign receive_start_task = s_reg.start_task;
  assign receive_stop_task  = s_reg.stop_task;
  assign irq                = s_reg.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_rxs_publish: assert property (
    (receive_started_event && s_reg.pub_rxs[CHAN_IDX_W] &&
     (int'(s_reg.pub_rxs[CHAN_IDX_W-1:0]) < NUM_CHANNELS))
    |=> channel_pulse[$past(s_reg.pub_rxs[CHAN_IDX_W-1:0])])
    else $error("rx-started pulse missing on channel");

  chk_txs_publish: assert property (
    (transmit_started_event && s_reg.pub_txs[CHAN_IDX_W] &&
     (int'(s_reg.pub_txs[CHAN_IDX_W-1:0]) < NUM_CHANNELS))
    |=> channel_pulse[$past(s_reg.pub_txs[CHAN_IDX_W-1:0])])
    else $error("tx-started pulse missing on channel");

  chk_txp_publish: assert property (
    (transmit_stopped_event && s_reg.pub_txp[CHAN_IDX_W] &&
     (int'(s_reg.pub_txp[CHAN_IDX_W-1:0]) < NUM_CHANNELS))
    |=> channel_pulse[$past(s_reg.pub_txp[CHAN_IDX_W-1:0])])
    else $error("tx-stopped pulse missing on channel");

  chk_pub_quiet: assert property (
    !(s_reg.pub_rxs[CHAN_IDX_W] || s_reg.pub_txs[CHAN_IDX_W] || s_reg.pub_txp[CHAN_IDX_W])
    |=> channel_pulse == '0)
    else $error("channel driven while publishing disabled");

  chk_short_start: assert property (
    receive_buffer_end_event |=> receive_start_task == $past(s_reg.sc_start))
    else $error("start task does not follow shortcut");

  chk_short_stop: assert property (
    receive_stop_task |-> $past(receive_buffer_end_event && s_reg.sc_stop))
    else $error("stop task without end-of-rx and shortcut");

  chk_short_write: assert property (
    (s_reg.wr_pend && s_reg.wr_addr == OFS_SHORTCUTS)
    |=> s_reg.sc_start == $past(hwdata[SC_START_BIT]) &&
        s_reg.sc_stop == $past(hwdata[SC_STOP_BIT]))
    else $error("shortcut register did not take write");

  chk_cts_lost_gate: assert property (
    (s_reg.int_mask == (32'h1 << IB_CTS_LOST)) && !s_reg.wr_pend
    |=> irq == s_reg.status[IB_CTS_LOST])
    else $error("lost clear-to-send irq gating wrong");

  chk_irq_or: assert property (
    irq == |(s_reg.status & s_reg.int_mask))
    else $error("irq differs from enabled pending OR");

  chk_set_alias: assert property (
    (s_reg.wr_pend && s_reg.wr_addr == OFS_INT_SET)
    |=> s_reg.int_mask == ($past(s_reg.int_mask) | ($past(hwdata) & INT_VALID)))
    else $error("set alias changed enables wrongly");

  chk_status_sticky: assert property (
    receive_started_event |=> s_reg.status[IB_RXSTART])
    else $error("event not captured in status");

  chk_status_clear: assert property (
    (s_reg.wr_pend && s_reg.wr_addr == OFS_INT_STATUS)
    |=> (s_reg.status & $past(hwdata) & INT_VALID & ~$past(ev_vec)) == 32'h0)
    else $error("status bits not cleared by write");

  // mask write takes valid bits only
  chk_mask_write: assert property (
    (s_reg.wr_pend && s_reg.wr_addr == OFS_INT_MASK)
    |=> s_reg.int_mask == ($past(hwdata) & INT_VALID))
    else $error("enable register did not take write");

  chk_irq_masked: assert property (
    (s_reg.int_mask == 32'h0) && !s_reg.wr_pend |=> !irq)
    else $error("irq raised with every enable clear");

  // channel pulse needs a routed event
  chk_chan_cause: assert property (
    (channel_pulse != '0)
    |-> $past(receive_started_event || transmit_started_event || transmit_stopped_event))
    else $error("channel pulse without routed event");

  // start task needs end-of-rx and shortcut
  chk_start_cause: assert property (
    receive_start_task |-> $past(receive_buffer_end_event && s_reg.sc_start))
    else $error("start task without end-of-rx and shortcut");

endmodule

// >>> uart_evt_pkg.sv
// ==========================================================
// register map, field layout and bus constants
package uart_evt_pkg;

  // ==========================================================
  // address decode
  localparam int              ADDR_W          = 12;
  localparam logic [11:0]     OFS_PUB_RXSTART = 12'h1cc;
  localparam logic [11:0]     OFS_PUB_TXSTART = 12'h1d0;
  localparam logic [11:0]     OFS_PUB_TXSTOP  = 12'h1d8;
  localparam logic [11:0]     OFS_SHORTCUTS   = 12'h200;
  localparam logic [11:0]     OFS_INT_MASK    = 12'h300;
  localparam logic [11:0]     OFS_INT_SET     = 12'h304;
  localparam logic [11:0]     OFS_INT_STATUS  = 12'h310;

  // ==========================================================
  // publish register layout
  localparam int              CHAN_IDX_W      = 4;
  localparam int              PUB_EN_BIT      = 31;
  localparam logic [31:0]     PUB_RESET       = 32'h0000_0000;

  // ==========================================================
  // shortcut register layout
  localparam int              SC_START_BIT    = 5;
  localparam int              SC_STOP_BIT     = 6;
  localparam logic [31:0]     SHORTCUT_RESET  = 32'h0000_0000;

  // ==========================================================
  // interrupt enable / status layout
  localparam int              IB_CTS          = 0;
  localparam int              IB_CTS_LOST     = 1;
  localparam int              IB_RXRDY        = 2;
  localparam int              IB_RX_END       = 4;
  localparam int              IB_TXSENT       = 7;
  localparam int              IB_TX_END       = 8;
  localparam int              IB_ERROR        = 9;
  localparam int              IB_RX_TIMEOUT   = 17;
  localparam int              IB_RXSTART      = 19;
  localparam int              IB_TXSTART      = 20;
  localparam int              IB_TXSTOP       = 22;
  localparam logic [31:0]     INT_VALID       = 32'h005a_0397;
  localparam logic [31:0]     INT_MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0]     STATUS_RESET    = 32'h0000_0000;

  // ==========================================================
  // bus signalling
  localparam int              HTRANS_ACT_BIT  = 1;
  localparam logic            HRESP_OKAY      = 1'b0;
  localparam logic [31:0]     RDATA_NONE      = 32'h0000_0000;

endpackage

// >>> event_publisher.sv
`timescale 1ns/1ns
// ==========================================================
// routes one event pulse onto one selected channel
module event_publisher #(
  parameter int NUM_CHANNELS = 16
) (
  // event and its publish configuration
  input  wire logic                               evt,
  input  wire logic                               enable,
  input  wire logic [uart_evt_pkg::CHAN_IDX_W-1:0] chan_idx,
  // one-hot channel drive
  output logic      [NUM_CHANNELS-1:0]            chan_hit
);
  import uart_evt_pkg::*;

  // refuse more channels than the index can reach
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << CHAN_IDX_W)) begin : g_bad_channels
    $error("NUM_CHANNELS out of range for the channel index");
  end

  // a disabled publisher drives no channel at all
  always_comb begin
    chan_hit = '0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (evt && enable && (chan_idx == CHAN_IDX_W'(i))) begin
        chan_hit[i] = 1'b1;
      end
    end
  end

endmodule

// >>> uart_far_model.sv
`timescale 1ns/1ns
// ==========================================================
// far side: uart core event source, channel and task monitor
module uart_far_model #(
  parameter int NUM_CHANNELS = 16
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // bench control
  input  wire logic [10:0]             fire,
  input  wire logic                    clr,
  // event pulses to the bank
  output logic      [10:0]             evt,
  // outputs of the bank
  input  wire logic [NUM_CHANNELS-1:0] channel_pulse,
  input  wire logic                    receive_start_task,
  input  wire logic                    receive_stop_task,
  // monitor results
  output logic      [NUM_CHANNELS-1:0] chan_seen,
  output logic      [7:0]              start_cnt,
  output logic      [7:0]              stop_cnt
);
  // events launched on the clock, one cycle each
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt <= '0;
    end else begin
      evt <= fire;
    end
  end

  // collect channel and task pulses since the last clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_seen <= '0;
      start_cnt <= '0;
      stop_cnt  <= '0;
    end else if (clr) begin
      chan_seen <= '0;
      start_cnt <= '0;
      stop_cnt  <= '0;
    end else begin
      chan_seen <= chan_seen | channel_pulse;
      start_cnt <= start_cnt + 8'(receive_start_task); // counts catch stretched pulses
      stop_cnt  <= stop_cnt + 8'(receive_stop_task);
    end
  end
endmodule

// >>> uart_event_routing_regs_tb.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench for the event routing register bank
module uart_event_routing_regs_tb;
  import uart_evt_pkg::*;
  localparam int EVB [11] = '{IB_CTS, IB_CTS_LOST, IB_RXRDY, IB_RX_END, IB_TXSENT, IB_TX_END,
                              IB_ERROR, IB_RX_TIMEOUT, IB_RXSTART, IB_TXSTART, IB_TXSTOP};
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, clr, irq, start_task, stop_task;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [10:0] fire, evt;
  logic [15:0] channel_pulse, chan_seen;
  logic [7:0]  start_cnt, stop_cnt;
  int          errors, tests_run;
  logic [11:0] pofs [3] = '{OFS_PUB_RXSTART, OFS_PUB_TXSTART, OFS_PUB_TXSTOP};
  int          pev [3] = '{8, 9, 10};
  logic [3:0]  pch [3] = '{4'hf, 4'h0, 4'h7};
  logic [31:0] scv [4] = '{32'h0000_0020, 32'h0000_0040, 32'h0000_0060, 32'h0000_0000};

  // ==========================================================
  // design and far-side model
  uart_event_routing_regs #(.NUM_CHANNELS(16)) dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .clear_to_send_event(evt[0]), .clear_to_send_lost_event(evt[1]),
    .rx_byte_ready_event(evt[2]), .receive_buffer_end_event(evt[3]),
    .tx_byte_sent_event(evt[4]), .transmit_buffer_end_event(evt[5]),
    .error_event(evt[6]), .receive_timeout_event(evt[7]),
    .receive_started_event(evt[8]), .transmit_started_event(evt[9]),
    .transmit_stopped_event(evt[10]), .receive_start_task(start_task),
    .receive_stop_task(stop_task), .channel_pulse(channel_pulse), .irq(irq));
  uart_far_model #(.NUM_CHANNELS(16)) far_u (
    .clk(clk), .rst(rst), .fire(fire), .clr(clr), .evt(evt),
    .channel_pulse(channel_pulse), .receive_start_task(start_task),
    .receive_stop_task(stop_task), .chan_seen(chan_seen), .start_cnt(start_cnt),
    .stop_cnt(stop_cnt));

  // ==========================================================
  // compare, bus and event tasks
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h0);
    cmp_word(rd, exp);
    cmp_bit(hresp, HRESP_OKAY);
  endtask
  task automatic pulse_evt(input int i);
    clr  <= 1'b1;
    fire <= 11'h1 << i;
    @(posedge clk);
    clr  <= 1'b0;
    fire <= 11'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk);
    cmp_bit(irq, exp);
    @(posedge clk);
  endtask
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, inputs at time zero and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, hsel, hwrite, clr} = 4'b1000;
    {haddr, hwdata, htrans, hsize, fire} = {64'h0, 2'b00, 3'b010, 11'h0};
    errors = 0;
    tests_run = 0;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values of every register
    foreach (pofs[p]) chk_rd(pofs[p], PUB_RESET);
    chk_rd(OFS_SHORTCUTS, SHORTCUT_RESET);
    chk_rd(OFS_INT_MASK, INT_MASK_RESET);
    chk_rd(OFS_INT_STATUS, STATUS_RESET);
    // unmapped place reads zero and ignores writes
    ahb_write(12'h100, 32'hffff_ffff);
    chk_rd(12'h100, 32'h0);
    ahb_write(OFS_PUB_RXSTART, 32'hffff_ffff);
    chk_rd(OFS_PUB_RXSTART, 32'h8000_000f);
    // each publisher, enabled then disabled, at channels 15, 0 and 7
    foreach (pofs[p]) begin
      ahb_write(pofs[p], 32'h8000_0000 | 32'(pch[p]));
      chk_rd(pofs[p], 32'h8000_0000 | 32'(pch[p]));
      pulse_evt(pev[p]);
      cmp_word(32'(chan_seen), 32'h1 << pch[p]);
      ahb_write(pofs[p], 32'(pch[p]));
      pulse_evt(pev[p]);
      cmp_word(32'(chan_seen), 32'h0);
    end
    // shortcut combinations on end of receive
    ahb_write(OFS_SHORTCUTS, 32'hffff_ffff);
    chk_rd(OFS_SHORTCUTS, 32'h0000_0060);
    foreach (scv[s]) begin
      ahb_write(OFS_SHORTCUTS, scv[s]);
      chk_rd(OFS_SHORTCUTS, scv[s]);
      pulse_evt(3);
      cmp_word(32'(start_cnt), 32'(scv[s][SC_START_BIT]));
      cmp_word(32'(stop_cnt), 32'(scv[s][SC_STOP_BIT]));
    end
    // enable bits, masking, set alias and clearing per event
    ahb_write(OFS_INT_MASK, 32'hffff_ffff);
    chk_rd(OFS_INT_MASK, INT_VALID);
    ahb_write(OFS_INT_MASK, 32'h0);
    // earlier scenarios left events pending: clear them all first
    ahb_write(OFS_INT_STATUS, 32'hffff_ffff);
    chk_rd(OFS_INT_STATUS, STATUS_RESET);
    for (int i = 0; i < 11; i++) begin
      pulse_evt(i);
      chk_rd(OFS_INT_STATUS, 32'h1 << EVB[i]);
      chk_irq(1'b0);
      ahb_write(OFS_INT_SET, 32'h1 << EVB[i]);
      chk_irq(1'b1);
      ahb_write(OFS_INT_SET, 32'h0);
      chk_rd(OFS_INT_MASK, 32'h1 << EVB[i]);
      ahb_write(OFS_INT_STATUS, 32'h1 << EVB[i]);
      chk_irq(1'b0);
      ahb_write(OFS_INT_MASK, 32'h0);
    end
    // a reset in mid-run clears irq and the rx-started publish, shortcut, enable and status registers
    ahb_write(OFS_SHORTCUTS, 32'h0000_0060);
    ahb_write(OFS_INT_MASK, INT_VALID);
    pulse_evt(0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp_bit(irq, 1'b0);
    chk_rd(OFS_PUB_RXSTART, PUB_RESET);
    chk_rd(OFS_SHORTCUTS, SHORTCUT_RESET);
    chk_rd(OFS_INT_MASK, INT_MASK_RESET);
    chk_rd(OFS_INT_STATUS, STATUS_RESET);
    print_verdict();
  end
endmodule
